// ==== timer3_pkg.sv ====
// Constants, field layout and shared types of the timer 3 control block
// How it works
// [RULE1] High byte rollover sets high overflow flag
// [RULE2] 16-bit wrap from FFFF to the reload value sets flag
// [RULE3] Set high flag requests interrupt when enabled
// [RULE4] Flags only cleared by software writing zero
// [RULE5] Low byte rollover sets low flag, any mode
// [RULE6] Low flag also interrupts when bit 5 set
// [RULE7] Bit 4 switches external capture mode
// [RULE8] Bit 3 picks 16-bit or two 8-bit counters
// [RULE9] Bit 2 runs or holds the count
// [RULE10] Split mode: run gates high byte only
// [RULE11] Bit 1 reads zero, writes ignored
// [RULE12] External select 0 means system clock /12
// [RULE13] Select 1: external oscillator /8, synchronised
// [RULE14] Split mode: one select serves both bytes
// [RULE15] Byte clock select 1 forces undivided clock
// [RULE16] 16-bit wrap loads 16-bit reload value
// [RULE17] Split mode: each byte reloads its byte
// [RULE18] Capture: falling /8 edge copies count, sets flag
// [RULE19] Counters step once per selected tick
package timer3_pkg;

   localparam logic [7:0] ADDR_CONTROL = 8'h91;
   localparam logic [7:0] ADDR_RELOAD_LOW = 8'h92;
   localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h93;
   localparam logic [7:0] ADDR_COUNT_LOW = 8'h94;
   localparam logic [7:0] ADDR_COUNT_HIGH = 8'h95;

   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] RELOAD_RESET = 16'h0000;
   localparam logic [7:0] BYTE_MAX = 8'hFF;
   localparam logic [15:0] WORD_MAX = 16'hFFFF;

   localparam int HIGH_OVF_BIT = 7;
   localparam int LOW_OVF_BIT = 6;
   localparam int LOW_IRQ_EN_BIT = 5;
   localparam int CAPTURE_EN_BIT = 4;
   localparam int SPLIT_BIT = 3;
   localparam int RUN_BIT = 2;
   localparam int UNUSED_BIT = 1;
   localparam int EXT_CLK_SEL_BIT = 0;

   // Prescaler ratios
   localparam int SYS_DIV = 12;
   localparam int EXT_DIV = 8;

   // Packed in register bit order, 7 down to 0
   typedef struct packed {
      logic highByteOverflowFlag;
      logic lowByteOverflowFlag;
      logic lowByteIrqEnable;
      logic captureModeEnable;
      logic splitModeSelect;
      logic runControl;
      logic unused;
      logic externalClockSelect;
   } control_t;

   typedef struct packed {
      logic sysDiv12Tick;
      logic extDiv8Tick;
      logic extDiv8Fall;
   } ticks_t;

endpackage

// ==== timer3_tick_source.sv ====
// Prescalers: system clock /12 and synchronised external oscillator /8
`timescale 1ns/1ps
`default_nettype none
module timer3_tick_source
   import timer3_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic extOscPin,
   output var ticks_t ticks
);

   logic extMeta_r, extSync_r, extPrev_r;
   logic [3:0] sysCnt_r, sysCnt_nxt;
   logic [1:0] extCnt_r, extCnt_nxt;
   logic div8_r, div8_nxt, div8Prev_r;
   logic extRise;

   always_comb begin
      extRise = extSync_r & ~extPrev_r;
      sysCnt_nxt = (sysCnt_r == 4'(SYS_DIV - 1)) ? 4'h0 : 4'(sysCnt_r + 4'h1); // [RULE12]
      extCnt_nxt = extCnt_r;
      div8_nxt = div8_r;
      if (extRise) begin
         // Four oscillator edges per half period gives /8
         extCnt_nxt = 2'(extCnt_r + 2'h1);
         if (extCnt_r == 2'(EXT_DIV / 2 - 1)) begin
            div8_nxt = ~div8_r; // [RULE13]
         end
      end
      ticks.sysDiv12Tick = (sysCnt_r == 4'h0);
      ticks.extDiv8Tick = div8_r & ~div8Prev_r;
      ticks.extDiv8Fall = ~div8_r & div8Prev_r;
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         extMeta_r <= 1'b0;
         extSync_r <= 1'b0;
         extPrev_r <= 1'b0;
         sysCnt_r <= 4'h0;
         extCnt_r <= 2'h0;
         div8_r <= 1'b0;
         div8Prev_r <= 1'b0;
      end else begin
         extMeta_r <= extOscPin; // [RULE13]
         extSync_r <= extMeta_r;
         extPrev_r <= extSync_r;
         sysCnt_r <= sysCnt_nxt;
         extCnt_r <= extCnt_nxt;
         div8_r <= div8_nxt;
         div8Prev_r <= div8_r;
      end
   end

endmodule
`default_nettype wire

// ==== timer3_control_and_flags.sv ====
// Timer 3: control register, flags, counters, reload and capture
`timescale 1ns/1ps
`default_nettype none
module timer3_control_and_flags
   import timer3_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [7:0] sfrAddr,
   input wire logic [7:0] sfrWrData,
   input wire logic sfrWrEn,
   input wire logic timerIrqEnable,
   input wire logic highByteClockSelect,
   input wire logic lowByteClockSelect,
   input wire logic extOscPin,
   output logic [7:0] sfrRdData,
   output logic timerIrqReq
);

   control_t ctl_r, ctl_nxt;
   logic [15:0] cnt_r, cnt_nxt;
   logic [15:0] rld_r, rld_nxt;
   logic [7:0] rdData_r, rdData_nxt;
   logic irq_r, irq_nxt;
   ticks_t ticks;
   logic srcTick, lowTick, highTick, highEvt, lowEvt, captureEvt;

   timer3_tick_source u_ticks (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .extOscPin(extOscPin),
      .ticks(ticks)
   );

   function automatic logic isWrite(input logic [7:0] addr, input logic [7:0] target,
                                    input logic en);
      return en && (addr == target);
   endfunction

   always_comb begin
      // One external select serves both bytes; byte selects override it
      srcTick = ctl_r.externalClockSelect ? ticks.extDiv8Tick : ticks.sysDiv12Tick; // [RULE14]
      lowTick = lowByteClockSelect ? 1'b1 : srcTick; // [RULE15]
      highTick = highByteClockSelect ? 1'b1 : srcTick; // [RULE15]
      captureEvt = ctl_r.captureModeEnable && ticks.extDiv8Fall; // [RULE7]
      highEvt = 1'b0;
      lowEvt = 1'b0;
      cnt_nxt = cnt_r;
      rld_nxt = rld_r;
      ctl_nxt = ctl_r;

      if (!ctl_r.splitModeSelect) begin // [RULE8]
         // 16-bit mode follows the low byte's clock selection
         if (ctl_r.runControl && lowTick) begin // [RULE9]
            cnt_nxt = 16'(cnt_r + 16'h0001); // [RULE19]
            lowEvt = (cnt_r[7:0] == BYTE_MAX); // [RULE5]
            if (cnt_r == WORD_MAX) begin
               cnt_nxt = rld_r; // [RULE16]
               highEvt = 1'b1; // [RULE2]
            end
         end
      end else begin
         if (lowTick) begin // [RULE10]
            cnt_nxt[7:0] = 8'(cnt_r[7:0] + 8'h01); // [RULE19]
            if (cnt_r[7:0] == BYTE_MAX) begin
               cnt_nxt[7:0] = rld_r[7:0]; // [RULE17]
               lowEvt = 1'b1; // [RULE5]
            end
         end
         if (ctl_r.runControl && highTick) begin // [RULE10]
            cnt_nxt[15:8] = 8'(cnt_r[15:8] + 8'h01);
            if (cnt_r[15:8] == BYTE_MAX) begin
               cnt_nxt[15:8] = rld_r[15:8]; // [RULE17]
               highEvt = 1'b1; // [RULE1]
            end
         end
      end

      // Software writes to the count win over a tick in the same cycle
      if (isWrite(sfrAddr, ADDR_COUNT_LOW, sfrWrEn)) begin
         cnt_nxt[7:0] = sfrWrData;
      end
      if (isWrite(sfrAddr, ADDR_COUNT_HIGH, sfrWrEn)) begin
         cnt_nxt[15:8] = sfrWrData;
      end
      if (isWrite(sfrAddr, ADDR_RELOAD_LOW, sfrWrEn)) begin
         rld_nxt[7:0] = sfrWrData;
      end
      if (isWrite(sfrAddr, ADDR_RELOAD_HIGH, sfrWrEn)) begin
         rld_nxt[15:8] = sfrWrData;
      end
      // Capture beats a reload write so no measurement is lost
      if (captureEvt) begin
         rld_nxt = cnt_r; // [RULE18]
         highEvt = 1'b1; // [RULE18]
      end
      if (isWrite(sfrAddr, ADDR_CONTROL, sfrWrEn)) begin
         ctl_nxt = control_t'(sfrWrData);
      end
      ctl_nxt.unused = 1'b0; // [RULE11]
      // Hardware set wins over a software clear in the same cycle
      ctl_nxt.highByteOverflowFlag = ctl_nxt.highByteOverflowFlag | highEvt; // [RULE4]
      ctl_nxt.lowByteOverflowFlag = ctl_nxt.lowByteOverflowFlag | lowEvt; // [RULE4]

      unique case (sfrAddr)
         ADDR_CONTROL: rdData_nxt = ctl_r;
         ADDR_RELOAD_LOW: rdData_nxt = rld_r[7:0];
         ADDR_RELOAD_HIGH: rdData_nxt = rld_r[15:8];
         ADDR_COUNT_LOW: rdData_nxt = cnt_r[7:0];
         ADDR_COUNT_HIGH: rdData_nxt = cnt_r[15:8];
         default: rdData_nxt = 8'h00;
      endcase

      irq_nxt = timerIrqEnable && (ctl_r.highByteOverflowFlag // [RULE3]
                || (ctl_r.lowByteIrqEnable && ctl_r.lowByteOverflowFlag)); // [RULE6]
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ctl_r <= control_t'(CONTROL_RESET);
         cnt_r <= COUNT_RESET;
         rld_r <= RELOAD_RESET;
         rdData_r <= 8'h00;
         irq_r <= 1'b0;
      end else begin
         ctl_r <= ctl_nxt;
         cnt_r <= cnt_nxt;
         rld_r <= rld_nxt;
         rdData_r <= rdData_nxt;
         irq_r <= irq_nxt;
      end
   end

   assign sfrRdData = rdData_r;
   assign timerIrqReq = irq_r;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   logic cntWrite;
   assign cntWrite = sfrWrEn && (sfrAddr == ADDR_COUNT_LOW || sfrAddr == ADDR_COUNT_HIGH);

   property p_wrap16;
      !ctl_r.splitModeSelect && ctl_r.runControl && lowTick && cnt_r == WORD_MAX && !cntWrite
      |=> ctl_r.highByteOverflowFlag && cnt_r == $past(rld_r);
   endproperty
   a_wrap16: assert property (p_wrap16) else $error("16-bit wrap lost"); // [RULE2]

   property p_splitHigh;
      ctl_r.splitModeSelect && ctl_r.runControl && highTick && cnt_r[15:8] == BYTE_MAX
      |=> ctl_r.highByteOverflowFlag;
   endproperty
   a_splitHigh: assert property (p_splitHigh) else $error("high byte flag missed"); // [RULE1]

   property p_lowFlag;
      (ctl_r.splitModeSelect || ctl_r.runControl) && lowTick && cnt_r[7:0] == BYTE_MAX
      |=> ctl_r.lowByteOverflowFlag;
   endproperty
   a_lowFlag: assert property (p_lowFlag) else $error("low byte flag missed"); // [RULE5]

   property p_flagHold;
      ctl_r.highByteOverflowFlag && !(sfrWrEn && sfrAddr == ADDR_CONTROL)
      |=> ctl_r.highByteOverflowFlag;
   endproperty
   a_flagHold: assert property (p_flagHold) else $error("flag cleared by hardware"); // [RULE4]

   property p_irqHigh;
      timerIrqEnable && ctl_r.highByteOverflowFlag |=> timerIrqReq;
   endproperty
   a_irqHigh: assert property (p_irqHigh) else $error("interrupt not raised"); // [RULE3]

   property p_irqLow;
      timerIrqEnable && ctl_r.lowByteIrqEnable && ctl_r.lowByteOverflowFlag |=> timerIrqReq;
   endproperty
   a_irqLow: assert property (p_irqLow) else $error("low interrupt not raised"); // [RULE6]

   property p_hold16;
      !ctl_r.splitModeSelect && !ctl_r.runControl && !cntWrite |=> $stable(cnt_r);
   endproperty
   a_hold16: assert property (p_hold16) else $error("count moved while stopped"); // [RULE9]

   // A reload value of all ones must not look like a stalled low byte
   property p_splitLowRuns;
      ctl_r.splitModeSelect && !ctl_r.runControl && lowByteClockSelect && !cntWrite
      |=> cnt_r[7:0] == (($past(cnt_r[7:0]) == BYTE_MAX) ? $past(rld_r[7:0])
                         : 8'($past(cnt_r[7:0]) + 8'h01)) && $stable(cnt_r[15:8]);
   endproperty
   a_splitLowRuns: assert property (p_splitLowRuns) else $error("split run gating wrong"); // [RULE10]

   property p_unusedZero;
      sfrAddr == ADDR_CONTROL |=> !sfrRdData[UNUSED_BIT];
   endproperty
   a_unusedZero: assert property (p_unusedZero) else $error("unused bit reads one"); // [RULE11]

   property p_div12;
      ticks.sysDiv12Tick |-> ##12 ticks.sysDiv12Tick;
   endproperty
   a_div12: assert property (p_div12) else $error("prescaler period wrong"); // [RULE12]

   property p_capture;
      captureEvt |=> ctl_r.highByteOverflowFlag && rld_r == $past(cnt_r);
   endproperty
   a_capture: assert property (p_capture) else $error("capture not taken"); // [RULE18]

   property p_byteSel;
      !ctl_r.splitModeSelect && ctl_r.runControl && lowByteClockSelect && cnt_r != WORD_MAX
      && !cntWrite |=> cnt_r == 16'($past(cnt_r) + 16'h0001);
   endproperty
   a_byteSel: assert property (p_byteSel) else $error("byte clock select ignored"); // [RULE15]

   property p_splitReload;
      ctl_r.splitModeSelect && lowTick && cnt_r[7:0] == BYTE_MAX && !cntWrite
      |=> cnt_r[7:0] == $past(rld_r[7:0]);
   endproperty
   a_splitReload: assert property (p_splitReload) else $error("reload lost"); // [RULE17]

   property p_irqOff;
      !timerIrqEnable |=> !timerIrqReq;
   endproperty
   a_irqOff: assert property (p_irqOff) else $error("interrupt while disabled"); // [RULE3]

   c_wrap16: cover property (!ctl_r.splitModeSelect && highEvt);
   c_splitLow: cover property (ctl_r.splitModeSelect && lowEvt);
   c_capture: cover property (captureEvt);
   c_irq: cover property (timerIrqReq);

endmodule
`default_nettype wire

// ==== timer3_osc_model.sv ====
// External oscillator source driving the timer's oscillator pin
`timescale 1ns/1ps
`default_nettype none
module timer3_osc_model #(
   parameter real HALF_NS = 23.0
) (
   output logic oscOut
);
   // Free running, phase unrelated to the system clock
   initial begin
      oscOut = 1'b0;
      #7.3;
      forever #(HALF_NS) oscOut = ~oscOut;
   end
endmodule
`default_nettype wire

// ==== test_timer3_control_and_flags.sv ====
// Self-checking bench for the timer 3 control and flag block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin errCount++; \
   $display("FAIL t=%0t got %h exp %h", $time, got, exp); end end
module test_timer3_control_and_flags;
   import timer3_pkg::*;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] sfrAddr = 8'h00;
   logic [7:0] sfrWrData = 8'h00;
   logic sfrWrEn = 1'b0;
   logic timerIrqEnable = 1'b0;
   logic highByteClockSelect = 1'b0;
   logic lowByteClockSelect = 1'b0;
   wire logic extOscPin;
   logic [7:0] sfrRdData;
   logic timerIrqReq;
   int errCount = 0;
   int compares = 0;
   logic [7:0] addrs [6] = '{ADDR_CONTROL, ADDR_RELOAD_LOW, ADDR_RELOAD_HIGH,
      ADDR_COUNT_LOW, ADDR_COUNT_HIGH, 8'h90};

   always #5 ref_clk = ~ref_clk;

   timer3_osc_model u_timer3_osc_model (.oscOut(extOscPin));

   timer3_control_and_flags u_timer3_control_and_flags (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .sfrAddr(sfrAddr), .sfrWrData(sfrWrData),
      .sfrWrEn(sfrWrEn), .timerIrqEnable(timerIrqEnable),
      .highByteClockSelect(highByteClockSelect), .lowByteClockSelect(lowByteClockSelect),
      .extOscPin(extOscPin), .sfrRdData(sfrRdData), .timerIrqReq(timerIrqReq));

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", compares, errCount);
      if (errCount == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      sfrAddr = a;
      sfrWrData = d;
      sfrWrEn = 1'b1;
      @(negedge ref_clk);
      sfrWrEn = 1'b0;
   endtask

   // Read data lags the address by one edge; two falls leave margin
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      sfrAddr = a;
      repeat (2) @(negedge ref_clk);
      d = sfrRdData;
   endtask

   task automatic wait_flag(input int b, input int lim);
      logic [7:0] v;
      for (int i = 0; i < lim; i++) begin
         rd(ADDR_CONTROL, v);
         if (v[b] === 1'b1)
            return;
      end
      errCount++;
      $display("FAIL t=%0t flag wait expired", $time);
      stop_test();
   endtask

   task automatic set_counts(input logic [7:0] hi, input logic [7:0] lo);
      wr(ADDR_COUNT_HIGH, hi);
      wr(ADDR_COUNT_LOW, lo);
   endtask

   // Oscillator tick in system cycles: 2 x 23 ns x 8 over 10 ns, rounded down
   localparam int OSC_TICK_CYCLES = 36;

   // Ticks a divided source gives over a run of so many system cycles
   function automatic int expTicks(input int cycles, input int period);
      return cycles / period;
   endfunction

   initial begin
      logic [7:0] v;
      logic [7:0] h;
      logic [7:0] r;
      logic [15:0] cnt;
      int e;
      r = 8'($urandom(93));
      repeat (16) @(posedge ref_clk);
      @(negedge ref_clk);
      sys_rst = 1'b0;
      foreach (addrs[i]) begin
         rd(addrs[i], v);
         `CHK(v, 8'h00)
      end
      timerIrqEnable = 1'b1;
      wr(ADDR_CONTROL, 8'hC2);
      rd(ADDR_CONTROL, v);
      `CHK(v, 8'hC0)
      `CHK(timerIrqReq, 1'b1)
      repeat (20) @(negedge ref_clk);
      rd(ADDR_CONTROL, v);
      `CHK(v, 8'hC0)
      wr(ADDR_CONTROL, 8'h00);
      repeat (2) @(negedge ref_clk);
      `CHK(timerIrqReq, 1'b0)
      lowByteClockSelect = 1'b1;
      for (int k = 0; k < 3; k++) begin
         r = 8'($urandom_range(8'hF0, 8'h01));
         wr(ADDR_RELOAD_HIGH, r);
         wr(ADDR_RELOAD_LOW, 8'h00);
         set_counts(8'hFF, 8'hF0);
         wr(ADDR_CONTROL, 8'h04);
         wait_flag(HIGH_OVF_BIT, 40);
         wr(ADDR_CONTROL, 8'hC0);
         rd(ADDR_CONTROL, v);
         `CHK(v, 8'hC0)
         `CHK(timerIrqReq, 1'b1)
         rd(ADDR_COUNT_HIGH, h);
         `CHK(h, r)
         rd(ADDR_COUNT_LOW, v);
         repeat (6) @(negedge ref_clk);
         rd(ADDR_COUNT_LOW, h);
         `CHK(h, v)
      end
      highByteClockSelect = 1'b1;
      wr(ADDR_CONTROL, 8'h00);
      wr(ADDR_RELOAD_LOW, 8'h50);
      wr(ADDR_RELOAD_HIGH, 8'h70);
      set_counts(8'hFE, 8'hF8);
      wr(ADDR_CONTROL, 8'h08);
      wait_flag(LOW_OVF_BIT, 40);
      rd(ADDR_CONTROL, v);
      `CHK(v[7], 1'b0)
      `CHK(timerIrqReq, 1'b0)
      rd(ADDR_COUNT_HIGH, v);
      `CHK(v, 8'hFE)
      rd(ADDR_COUNT_LOW, v);
      `CHK(v >= 8'h50 && v < 8'h70, 1'b1)
      wr(ADDR_CONTROL, 8'h68);
      repeat (2) @(negedge ref_clk);
      `CHK(timerIrqReq, 1'b1)
      wr(ADDR_CONTROL, 8'h0C);
      wait_flag(HIGH_OVF_BIT, 20);
      rd(ADDR_COUNT_HIGH, v);
      `CHK(v >= 8'h70 && v < 8'h80, 1'b1)
      // Divided sources: fixed runs, count judged by the divide ratio
      wr(ADDR_CONTROL, 8'h00);
      lowByteClockSelect = 1'b0;
      set_counts(8'h00, 8'h00);
      wr(ADDR_CONTROL, 8'h04);
      repeat (120) @(negedge ref_clk);
      wr(ADDR_CONTROL, 8'h00);
      rd(ADDR_COUNT_LOW, v);
      e = expTicks(122, SYS_DIV);
      `CHK(int'(v) >= e - 1 && int'(v) <= e + 1, 1'b1)
      set_counts(8'h00, 8'h00);
      wr(ADDR_CONTROL, 8'h05);
      repeat (736) @(negedge ref_clk);
      rd(ADDR_CONTROL, v);
      `CHK(v[7], 1'b0)
      wr(ADDR_CONTROL, 8'h00);
      rd(ADDR_COUNT_LOW, v);
      e = expTicks(740, OSC_TICK_CYCLES);
      `CHK(int'(v) >= e - 2 && int'(v) <= e + 2, 1'b1)
      // Split mode on the divided oscillator: one select drives both bytes
      highByteClockSelect = 1'b0;
      set_counts(8'h00, 8'h00);
      wr(ADDR_CONTROL, 8'h0D);
      repeat (736) @(negedge ref_clk);
      wr(ADDR_CONTROL, 8'h08);
      rd(ADDR_COUNT_HIGH, v);
      `CHK(int'(v) >= e - 2 && int'(v) <= e + 2, 1'b1)
      rd(ADDR_COUNT_LOW, v);
      `CHK(int'(v) >= e - 2 && int'(v) <= e + 2, 1'b1)
      lowByteClockSelect = 1'b1;
      set_counts(8'h00, 8'h00);
      wr(ADDR_CONTROL, 8'h15);
      wait_flag(HIGH_OVF_BIT, 60);
      wr(ADDR_CONTROL, 8'h80);
      rd(ADDR_RELOAD_HIGH, h);
      rd(ADDR_RELOAD_LOW, r);
      rd(ADDR_COUNT_HIGH, v);
      cnt[15:8] = v;
      rd(ADDR_COUNT_LOW, v);
      cnt[7:0] = v;
      `CHK({h, r} <= cnt && cnt - {h, r} < 16'h003C, 1'b1)
      stop_test();
   end
endmodule
`default_nettype wire
